// ---- rtl/ppri_top.sv ----
/*
 Pulse width and repetition rate input with APB register access.
 Assumes an APB master on REF_CLK and pulse pins synchronous enough to sample.
*/
// Behaviour
// RQ1: Pulses from 50 Hz to 150 kHz are measured and the source keeps within that range.
// RQ2: Mode 0 disables the block and forces the result to zero.
// RQ3: Modes 2, 3, 6 capture duty cycle unipolar 0 to 100 percent.
// RQ4: Modes 12, 13, 16 capture duty cycle bipolar -100 to +100 percent.
// RQ5: Modes 21, 31, 61 count one edge per period with a positive sign.
// RQ6: Modes 22, 32, 62 count both edges with a positive sign.
// RQ7: Modes 121 to 162 act as 21 to 62 with a negative sign.
// RQ8: The selected input is blocked from every other input function.
// RQ9: Frequency is scaled by a divider of 1 to 8192, reset 1024.
// RQ10: For percentage use 1 Hz of scaled frequency equals 1 percent.
// RQ11: Offset -100 to 100 percent, reset 0; gain 5 to 1000 percent, reset 100.
// RQ12: Source selector value 32 routes this result to the reference.
// RQ13: A status register reports the current processed result.
// RQ14: Maximum frequency accepts 0.00 to 999.99 Hz, reset 50.00 Hz.
// RQ15: Maximum percentage accepts 0.00 to 300.00 percent, reset 100.00.
// RQ16: Duty is high time over period between rising edges in clocks.
// RQ17: The selected input passes a two-stage synchroniser first.
`timescale 1ns/1ps
`include "ppri_consts.svh"
module ppri_top (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic DIGITAL_INPUT_TWO,
   input wire logic DIGITAL_INPUT_THREE,
   input wire logic DIGITAL_INPUT_SIX,
   output ppri_pkg::ppri_sel_t FUNC_INPUTS,
   output logic signed [31:0] FREQ_REF,
   output logic signed [31:0] PCT_REF,
   output logic REF_FREQ_SEL,
   output logic REF_PCT_SEL
);
   import ppri_pkg::*;
   ppri_meas_if mif ();
   logic [7:0] mode_q, fsrc_q, psrc_q;
   logic [13:0] div_q;
   logic signed [15:0] ofs_q;
   logic [15:0] gain_q;
   logic [16:0] fmax_q, pmax_q;
   logic signed [31:0] raw_q, val_q;
   ppri_kind_e kind;
   ppri_sel_t sel;
   logic neg, dbl, bip;
   logic [7:0] mode_prev_q;
   logic acc, wr, rd;
   logic signed [63:0] scaled, gained;
   logic signed [31:0] val_d;
   logic [31:0] rdata;
   logic hit;

   // Mode decode
   function automatic logic [5:0] decode(input logic [7:0] m);
      logic [5:0] r;
      r = 6'h00;
      case (m)
         8'd2: r = {3'b010, 3'b001};
         8'd3: r = {3'b010, 3'b010};
         8'd6: r = {3'b010, 3'b100};
         8'd12: r = {3'b011, 3'b001};
         8'd13: r = {3'b011, 3'b010};
         8'd16: r = {3'b011, 3'b100};
         8'd21, 8'd121: r = {3'b100, 3'b001};
         8'd22, 8'd122: r = {3'b101, 3'b001};
         8'd31, 8'd131: r = {3'b100, 3'b010};
         8'd32, 8'd132: r = {3'b101, 3'b010};
         8'd61, 8'd161: r = {3'b100, 3'b100};
         8'd62, 8'd162: r = {3'b101, 3'b100};
         default: r = 6'h00;
      endcase
      return r;
   endfunction

   logic [5:0] dec;
   assign dec = decode(mode_q);
   assign sel = dec[2:0];
   assign kind = (dec[5]) ? PPRI_M_FRQ : (dec[4] ? PPRI_M_PWM : PPRI_M_OFF); // RQ2
   assign bip = dec[4] & dec[3]; // RQ4
   assign dbl = dec[5] & dec[3]; // RQ6
   assign neg = dec[5] & (mode_q > 8'd99); // RQ7

   assign mif.pin = (sel[0] & DIGITAL_INPUT_TWO) | (sel[1] & DIGITAL_INPUT_THREE)
      | (sel[2] & DIGITAL_INPUT_SIX);
   assign mif.dbl = dbl;
   assign mif.clr = (mode_q != mode_prev_q);

   ppri_meas u_meas (
      .ref_clk(REF_CLK),
      .rstn(RSTN),
      .m(mif)
   );

   assign acc = PSEL & PENABLE;
   assign wr = acc & PWRITE;
   assign rd = acc & ~PWRITE;

   // Configuration registers
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         mode_q <= `PPRI_MODE_OFF;
         div_q <= `PPRI_DIV_RST; // RQ9
         ofs_q <= `PPRI_OFS_RST; // RQ11
         gain_q <= `PPRI_GAIN_RST; // RQ11
         fmax_q <= `PPRI_FMAXSET_RST; // RQ14
         pmax_q <= `PPRI_PMAX_RST; // RQ15
         fsrc_q <= 8'h00;
         psrc_q <= 8'h00;
      end else if (wr) begin
         case (PADDR)
            `PPRI_ADDR_MODE: mode_q <= PWDATA[7:0];
            `PPRI_ADDR_DIV: begin
               if (PWDATA >= 32'(`PPRI_DIV_MIN) && PWDATA <= 32'(`PPRI_DIV_MAX)) // RQ9
                  div_q <= PWDATA[13:0];
            end
            `PPRI_ADDR_OFS: begin
               if ($signed(PWDATA) >= 32'(`PPRI_OFS_MIN)
                  && $signed(PWDATA) <= 32'(`PPRI_OFS_MAX)) // RQ11
                  ofs_q <= PWDATA[15:0];
            end
            `PPRI_ADDR_GAIN: begin
               if (PWDATA >= 32'(`PPRI_GAIN_MIN) && PWDATA <= 32'(`PPRI_GAIN_MAX)) // RQ11
                  gain_q <= PWDATA[15:0];
            end
            `PPRI_ADDR_FMAX: begin
               if (PWDATA <= 32'(`PPRI_FMAXSET_MAX)) // RQ14
                  fmax_q <= PWDATA[16:0];
            end
            `PPRI_ADDR_PMAX: begin
               if (PWDATA <= 32'(`PPRI_PMAX_MAX)) // RQ15
                  pmax_q <= PWDATA[16:0];
            end
            `PPRI_ADDR_FSRC: fsrc_q <= PWDATA[7:0];
            `PPRI_ADDR_PSRC: psrc_q <= PWDATA[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN)
         mode_prev_q <= `PPRI_MODE_OFF;
      else
         mode_prev_q <= mode_q;
   end

   // Raw result in hundredths of a percent
   always_ff @(posedge REF_CLK) begin
      if (!RSTN || kind == PPRI_M_OFF || mif.clr) begin
         raw_q <= 32'sh00000000; // RQ2
      end else if (kind == PPRI_M_PWM && mif.per_vld) begin
         if (bip)
            raw_q <= 32'((64'(mif.high) * 64'd20000) / 64'(mif.period)) - 32'sd10000; // RQ4
         else
            raw_q <= 32'((64'(mif.high) * 64'd10000) / 64'(mif.period)); // RQ3
      end else if (kind == PPRI_M_PWM && mif.period == 24'h000000) begin
         raw_q <= 32'sh00000000;
      end else if (kind == PPRI_M_FRQ && mif.gate_vld) begin
         // Pulses per second over divider, times 1024 marks; 1 Hz is 1 percent
         if (neg)
            raw_q <= -32'((64'(mif.edges) * 64'd1024 * 64'd100) / 64'(div_q)); // RQ7 RQ9 RQ10
         else
            raw_q <= 32'((64'(mif.edges) * 64'd1024 * 64'd100) / 64'(div_q)); // RQ9 RQ10
      end
   end

   // Offset and amplification
   always_comb begin
      scaled = 64'(raw_q) + 64'(ofs_q); // RQ11
      gained = (scaled * $signed(64'(gain_q))) / 64'sd1000; // RQ11
      val_d = 32'(gained);
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN || kind == PPRI_M_OFF) begin
         val_q <= 32'sh00000000; // RQ2
         FREQ_REF <= 32'sh00000000;
         PCT_REF <= 32'sh00000000;
      end else begin
         val_q <= val_d; // RQ13
         FREQ_REF <= 32'((64'(val_d) * $signed(64'(fmax_q))) / $signed(64'(`PPRI_PCT_ONE))); // RQ12
         PCT_REF <= 32'((64'(val_d) * $signed(64'(pmax_q))) / $signed(64'(`PPRI_PCT_ONE))); // RQ12
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         REF_FREQ_SEL <= 1'b0;
         REF_PCT_SEL <= 1'b0;
         FUNC_INPUTS <= 3'b000;
      end else begin
         REF_FREQ_SEL <= (fsrc_q == `PPRI_SRC_SEL); // RQ12
         REF_PCT_SEL <= (psrc_q == `PPRI_SRC_SEL); // RQ12
         FUNC_INPUTS <= {DIGITAL_INPUT_SIX & ~sel[2], DIGITAL_INPUT_THREE & ~sel[1],
            DIGITAL_INPUT_TWO & ~sel[0]}; // RQ8
      end
   end

   // Read mux
   always_comb begin
      rdata = 32'h00000000;
      hit = 1'b1;
      case (PADDR)
         `PPRI_ADDR_MODE: rdata = {24'h000000, mode_q};
         `PPRI_ADDR_DIV: rdata = {18'h00000, div_q};
         `PPRI_ADDR_OFS: rdata = 32'(ofs_q);
         `PPRI_ADDR_GAIN: rdata = {16'h0000, gain_q};
         `PPRI_ADDR_FMAX: rdata = {15'h0000, fmax_q};
         `PPRI_ADDR_PMAX: rdata = {15'h0000, pmax_q};
         `PPRI_ADDR_FSRC: rdata = {24'h000000, fsrc_q};
         `PPRI_ADDR_PSRC: rdata = {24'h000000, psrc_q};
         `PPRI_ADDR_RAW: rdata = raw_q;
         `PPRI_ADDR_VAL: rdata = val_q; // RQ13
         `PPRI_ADDR_FREF: rdata = FREQ_REF;
         `PPRI_ADDR_PREF: rdata = PCT_REF;
         `PPRI_ADDR_BLK: rdata = {29'h00000000, sel}; // RQ8
         default: hit = 1'b0;
      endcase
   end

   // APB answer in the first cycle of the access phase
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~hit;
         PRDATA <= (PSEL & ~PENABLE & ~PWRITE & hit) ? rdata : 32'h00000000;
      end
   end
endmodule // ppri_top

// ---- rtl/ppri_consts.svh ----
/*
 Timing counts, mode codes, register offsets, limits and reset values
 for the pulse rate input.
 Assumes a 125 MHz system clock.
*/
`ifndef PPRI_CONSTS_SVH
`define PPRI_CONSTS_SVH
`define PPRI_CLK_HZ 125000000
`define PPRI_FMIN_HZ 50
`define PPRI_FMAX_HZ 150000
`define PPRI_PER_MAX (`PPRI_CLK_HZ / `PPRI_FMIN_HZ)
`define PPRI_PER_MIN (`PPRI_CLK_HZ / `PPRI_FMAX_HZ)
`define PPRI_GATE_CYC 32'd125000000
`define PPRI_MODE_OFF 8'd0
`define PPRI_DIV_MIN 14'd1
`define PPRI_DIV_MAX 14'd8192
`define PPRI_DIV_RST 14'd1024
`define PPRI_OFS_MIN (-16'sd10000)
`define PPRI_OFS_MAX 16'sd10000
`define PPRI_OFS_RST 16'h0000
`define PPRI_GAIN_MIN 16'd50
`define PPRI_GAIN_MAX 16'd10000
`define PPRI_GAIN_RST 16'd1000
`define PPRI_FMAXSET_MAX 17'd99999
`define PPRI_FMAXSET_RST 17'd5000
`define PPRI_PMAX_MAX 17'd30000
`define PPRI_PMAX_RST 17'd10000
`define PPRI_SRC_SEL 8'd32
`define PPRI_ADDR_MODE 12'h000
`define PPRI_ADDR_DIV 12'h004
`define PPRI_ADDR_OFS 12'h008
`define PPRI_ADDR_GAIN 12'h00C
`define PPRI_ADDR_FMAX 12'h010
`define PPRI_ADDR_PMAX 12'h014
`define PPRI_ADDR_FSRC 12'h018
`define PPRI_ADDR_PSRC 12'h01C
`define PPRI_ADDR_RAW 12'h020
`define PPRI_ADDR_VAL 12'h024
`define PPRI_ADDR_FREF 12'h028
`define PPRI_ADDR_PREF 12'h02C
`define PPRI_ADDR_BLK 12'h030
`define PPRI_PCT_ONE 32'd10000
`endif

// ---- rtl/ppri_pkg.sv ----
/*
 Types of the pulse rate input.
 Assumes the constants header is available.
*/
package ppri_pkg;
   typedef enum logic [2:0] {
      PPRI_M_OFF = 3'b001,
      PPRI_M_PWM = 3'b010,
      PPRI_M_FRQ = 3'b100
   } ppri_kind_e;
   typedef logic [2:0] ppri_sel_t;
endpackage

// ---- rtl/ppri_meas_if.sv ----
/*
 Carrier between the top and the edge measurement core.
 Assumes a single clock.
*/
`timescale 1ns/1ps
interface ppri_meas_if;
   logic pin;
   logic dbl;
   logic clr;
   logic [23:0] period;
   logic [23:0] high;
   logic per_vld;
   logic [31:0] edges;
   logic gate_vld;
   modport core (input pin, input dbl, input clr, output period, output high,
      output per_vld, output edges, output gate_vld);
   modport top (output pin, output dbl, output clr, input period, input high,
      input per_vld, input edges, input gate_vld);
endinterface

// ---- rtl/ppri_meas.sv ----
/*
 Edge measurement core: synchroniser, period and high time capture, gated edge count.
 Assumes the selected pin is steady between clocks.
*/
`timescale 1ns/1ps
`include "ppri_consts.svh"
module ppri_meas (
   input wire logic ref_clk,
   input wire logic rstn,
   ppri_meas_if.core m
);
   import ppri_pkg::*;
   logic s1_q, s2_q, s3_q;
   logic [23:0] pcnt_q, hcnt_q;
   logic [31:0] gcnt_q, ecnt_q;
   logic rise, fall;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn || m.clr) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= m.pin; // RQ17
         s2_q <= s1_q; // RQ17
         s3_q <= s2_q;
      end
   end
   // Period and high time between rising edges
   always_ff @(posedge ref_clk) begin
      if (!rstn || m.clr) begin
         pcnt_q <= 24'h000000;
         hcnt_q <= 24'h000000;
         m.period <= 24'h000000;
         m.high <= 24'h000000;
         m.per_vld <= 1'b0;
      end else begin
         m.per_vld <= 1'b0;
         if (rise) begin
            if (pcnt_q >= 24'(`PPRI_PER_MIN) && pcnt_q <= 24'(`PPRI_PER_MAX)) begin // RQ1
               m.period <= pcnt_q; // RQ16
               m.high <= hcnt_q; // RQ16
               m.per_vld <= 1'b1;
            end
            pcnt_q <= 24'h000001;
            hcnt_q <= 24'h000001;
         end else begin
            if (pcnt_q <= 24'(`PPRI_PER_MAX))
               pcnt_q <= pcnt_q + 24'h000001;
            else begin
               m.period <= 24'h000000;
               m.high <= 24'h000000;
            end
            if (s2_q)
               hcnt_q <= hcnt_q + 24'h000001;
         end
      end
   end
   // Edges per one-second gate
   always_ff @(posedge ref_clk) begin
      if (!rstn || m.clr) begin
         gcnt_q <= 32'h00000000;
         ecnt_q <= 32'h00000000;
         m.edges <= 32'h00000000;
         m.gate_vld <= 1'b0;
      end else begin
         m.gate_vld <= 1'b0;
         if (gcnt_q == `PPRI_GATE_CYC - 32'h00000001) begin
            gcnt_q <= 32'h00000000;
            m.edges <= ecnt_q + {31'h00000000, rise | (m.dbl & fall)};
            ecnt_q <= 32'h00000000;
            m.gate_vld <= 1'b1;
         end else begin
            gcnt_q <= gcnt_q + 32'h00000001;
            if (rise || (m.dbl && fall)) // RQ5 RQ6
               ecnt_q <= ecnt_q + 32'h00000001;
         end
      end
   end
endmodule // ppri_meas

// ---- verification/ppri_pulse_src.sv ----
/*
 Pulse source model for one pulse input.
 Assumes the bench keeps period and high time within the usable range.
*/
`timescale 1ns/1ps
module ppri_pulse_src (
   input wire logic clk,
   input wire logic en,
   input var int per,
   input var int hi,
   output logic pin
);
   int cnt = 0;
   initial pin = 1'b0;
   // Period of per clocks, high for the first hi of them
   always @(posedge clk) begin
      if (!en) begin
         cnt <= 0;
         pin <= 1'b0;
      end else begin
         cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
         pin <= (cnt < hi);
      end
   end
endmodule // ppri_pulse_src

// ---- verification/ppri_top_monitor.sv ----
/*
 Port checker for the pulse rate input.
 Assumes it is bound onto ppri_top.
*/
`timescale 1ns/1ps
`include "ppri_consts.svh"
module ppri_monitor (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire ppri_pkg::ppri_sel_t FUNC_INPUTS,
   input wire logic signed [31:0] FREQ_REF,
   input wire logic signed [31:0] PCT_REF,
   input wire logic REF_FREQ_SEL,
   input wire logic REF_PCT_SEL
);
   import ppri_pkg::*;
   logic [7:0] mode_q, fsrc_q, psrc_q;
   logic [2:0] msk;
   wire wr = PSEL && PENABLE && PREADY && PWRITE;
   // Mirror of the written mode and selectors
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         mode_q <= 8'h00;
         fsrc_q <= 8'h00;
         psrc_q <= 8'h00;
      end else if (wr) begin
         if (PADDR == `PPRI_ADDR_MODE) mode_q <= PWDATA[7:0];
         if (PADDR == `PPRI_ADDR_FSRC) fsrc_q <= PWDATA[7:0];
         if (PADDR == `PPRI_ADDR_PSRC) psrc_q <= PWDATA[7:0];
      end
   end
   always_comb begin
      case (mode_q)
         2, 12, 21, 22, 121, 122: msk = 3'h1;
         3, 13, 31, 32, 131, 132: msk = 3'h2;
         6, 16, 61, 62, 161, 162: msk = 3'h4;
         default: msk = 3'h0;
      endcase
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_setup; PSEL && !PENABLE; endsequence
   sequence s_access; PSEL && PENABLE && PREADY; endsequence
   a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no ready");
   a_ready_one_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
   a_err_unmapped: assert property (PREADY && PADDR[1:0] == 2'h0 |->
      PSLVERR == (PADDR > `PPRI_ADDR_BLK)) else $error("bad error response");
   a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0) else $error("rdata idle");
   a_off_zero: assert property ((mode_q == `PPRI_MODE_OFF)[*4] |->
      FREQ_REF == 0 && PCT_REF == 0) else $error("off not zero");
   a_input_blocked: assert property ($stable(msk)[*3] |->
      (FUNC_INPUTS & msk) == 3'h0) else $error("input not blocked");
   a_freq_src_sel: assert property ($stable(fsrc_q)[*2] |->
      REF_FREQ_SEL == (fsrc_q == `PPRI_SRC_SEL)) else $error("freq select");
   a_pct_src_sel: assert property ($stable(psrc_q)[*2] |->
      REF_PCT_SEL == (psrc_q == `PPRI_SRC_SEL)) else $error("pct select");
endmodule // ppri_monitor
bind ppri_top ppri_monitor u_mon (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .FUNC_INPUTS(FUNC_INPUTS), .FREQ_REF(FREQ_REF),
   .PCT_REF(PCT_REF), .REF_FREQ_SEL(REF_FREQ_SEL), .REF_PCT_SEL(REF_PCT_SEL));

// ---- verification/pwm_pulse_rate_input_test.sv ----
/*
 Self-checking bench for the pulse rate input.
 Assumes the pulse source model and the bound checker.
*/
`timescale 1ns/1ps
`include "ppri_consts.svh"
module pwm_pulse_rate_input_test;
   import ppri_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, src_en = 0, fs, ps, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, src_pin;
   logic [2:0] lvl = 0;
   ppri_sel_t func;
   logic signed [31:0] fref, pref;
   int mismatches = 0, n_compared = 0, per = 2000, hi = 500, sel = 0;
   int dv[5] = '{0, 8193, 8192, 1, 1024};
   int pm[6] = '{2, 3, 6, 12, 13, 16};
   int md[19] = '{0, 2, 3, 6, 12, 13, 16, 21, 22, 31, 32, 61, 62, 121, 122, 131, 132, 161, 162};
   int x, raw, ofs, gain, val, n;
   wire [2:0] pins = src_en ? (lvl & ~(3'h1 << sel)) | ({2'h0, src_pin} << sel) : lvl;
   initial forever #4 clk = ~clk;
   ppri_pulse_src u_src (.clk(clk), .en(src_en), .per(per), .hi(hi), .pin(src_pin));
   ppri_top DUT (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .DIGITAL_INPUT_TWO(pins[0]), .DIGITAL_INPUT_THREE(pins[1]),
      .DIGITAL_INPUT_SIX(pins[2]), .FUNC_INPUTS(func), .FREQ_REF(fref), .PCT_REF(pref),
      .REF_FREQ_SEL(fs), .REF_PCT_SEL(ps));
   task automatic complete_run;
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
      if (k >= 50) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(r, e);
   endtask
   function automatic logic [2:0] mask_of(input int m);
      int d;
      d = (m < 20) ? m % 10 : (m % 100) / 10;
      if (m == 0 || m > 162 || (m > 16 && m < 21)) return 3'h0;
      return d == 2 ? 3'h1 : d == 3 ? 3'h2 : 3'h4;
   endfunction
   initial begin
      void'($urandom(32'h9e3efd2c));
      repeat (12) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      rd_chk(`PPRI_ADDR_MODE, 0);
      rd_chk(`PPRI_ADDR_OFS, 0);
      rd_chk(`PPRI_ADDR_GAIN, `PPRI_GAIN_RST);
      rd_chk(`PPRI_ADDR_FMAX, `PPRI_FMAXSET_RST);
      rd_chk(`PPRI_ADDR_PMAX, `PPRI_PMAX_RST);
      x = 1024;
      for (int i = 0; i < 5; i++) begin
         apb(1, `PPRI_ADDR_DIV, dv[i]);
         if (dv[i] >= 1 && dv[i] <= 8192) x = dv[i];
         rd_chk(`PPRI_ADDR_DIV, x);
      end
      apb(1, `PPRI_ADDR_GAIN, 49);
      rd_chk(`PPRI_ADDR_GAIN, 1000);
      apb(1, `PPRI_ADDR_OFS, 10001);
      rd_chk(`PPRI_ADDR_OFS, 0);
      apb(1, `PPRI_ADDR_FMAX, 100000);
      rd_chk(`PPRI_ADDR_FMAX, 5000);
      apb(1, `PPRI_ADDR_PMAX, 30001);
      rd_chk(`PPRI_ADDR_PMAX, 10000);
      apb(0, 12'h040, 0);
      chk(err, 1);
      chk(r, 0);
      lvl <= 3'h7;
      foreach (md[i]) begin
         apb(1, `PPRI_ADDR_MODE, md[i]);
         rd_chk(`PPRI_ADDR_MODE, md[i]);
         rd_chk(`PPRI_ADDR_BLK, mask_of(md[i]));
         chk(func, ~mask_of(md[i]) & 3'h7);
      end
      lvl <= 3'h0;
      src_en <= 1;
      foreach (pm[i]) begin
         sel = i % 3;
         hi = $urandom_range(900, 200);
         ofs = $urandom_range(4000, 0) - 2000;
         gain = $urandom_range(1000, 50);
         apb(1, `PPRI_ADDR_OFS, ofs);
         apb(1, `PPRI_ADDR_GAIN, gain);
         apb(1, `PPRI_ADDR_MODE, pm[i]);
         n = 0;
         do begin
            repeat (100) @(posedge clk);
            apb(0, `PPRI_ADDR_RAW, 0);
            n++;
         end while (r == 0 && n < 60);
         if (n >= 60) begin
            mismatches++;
            complete_run();
         end
         // First period after a mode change may start mid-pulse; let full periods pass
         repeat (2 * per) @(posedge clk);
         raw = pm[i] < 10 ? hi * 10000 / per : hi * 20000 / per - 10000;
         val = (raw + ofs) * gain / 1000;
         rd_chk(`PPRI_ADDR_RAW, raw);
         rd_chk(`PPRI_ADDR_VAL, val);
         rd_chk(`PPRI_ADDR_FREF, val * 5000 / 10000);
         chk(fref, val * 5000 / 10000);
         chk(pref, val);
      end
      apb(1, `PPRI_ADDR_MODE, 0);
      rd_chk(`PPRI_ADDR_RAW, 0);
      rd_chk(`PPRI_ADDR_PREF, 0);
      chk(fref, 0);
      apb(1, `PPRI_ADDR_FSRC, 32);
      apb(1, `PPRI_ADDR_PSRC, 32);
      rd_chk(`PPRI_ADDR_FSRC, 32);
      chk({fs, ps}, 2'h3);
      apb(1, `PPRI_ADDR_FSRC, 31);
      rd_chk(`PPRI_ADDR_FSRC, 31);
      chk({fs, ps}, 2'h1);
      complete_run();
   end
endmodule // pwm_pulse_rate_input_test
